// ---- design/scl_params.svh ----
// Register map, field layout and timing constants of the strap loader
// Assumes: included by the package and both modules, no other header needed
`ifndef SCL_PARAMS_SVH
`define SCL_PARAMS_SVH

// Register byte offsets
`define SCL_ADDR_STATUS     8'h00
`define SCL_ADDR_CTRL       8'h04
`define SCL_ADDR_SETUP      8'h08
`define SCL_ADDR_TOKEN      8'h0C
`define SCL_ADDR_OUT        8'h10
`define SCL_ADDR_IN         8'h14

// Field positions
`define SCL_CTRL_START      0
`define SCL_CTRL_SWRST      1
`define SCL_SETUP_MAX_LSB   0
`define SCL_SETUP_CODE_LSB  4
`define SCL_SETUP_OD_A      8
`define SCL_SETUP_OD_B      9
`define SCL_STRAP_NID_MSB   3
`define SCL_STRAP_PAGE      4
`define SCL_STRAP_DIR_LSB   5
`define SCL_DIR_C           0
`define SCL_DIR_DLO         1
`define SCL_DIR_FLAG        2

// Reset values and limits
`define SCL_SETUP_RESET     32'h0000_0300
`define SCL_SETUP_RESET_MAX (4'((`SCL_SETUP_RESET) >> `SCL_SETUP_MAX_LSB))
`define SCL_SETUP_RESET_BIT(b) (1'((`SCL_SETUP_RESET) >> (b)))
`define SCL_ID_FIRST        4'h1
`define SCL_ID_MIN_HIGHEST  4'h2
`define SCL_ID_MAX_SMALL    4'h7
`define SCL_ID_MAX_LARGE    4'hF
`define SCL_TXD_IDLE        1'h1
`define SCL_RESP_OKAY       2'h0
`define SCL_RESP_SLVERR     2'h2

// Timing: times in ns at the reference rate, link rate is clock / DIV
`define SCL_RATE_DIV        8
`define SCL_REF_RATE_KBPS   2500
`define SCL_BURST_128_NS    1070000
`define SCL_BURST_64_NS     790000
`define SCL_SKIP_NS         93600
`define SCL_NS_TO_CYC(ns)   ((64'(ns) * `SCL_REF_RATE_KBPS * `SCL_RATE_DIV) / 64'd1000000)

`endif

// ---- design/scl_pkg.sv ----
// Types shared by the strap loader modules
// Assumes: scl_params.svh on the include path
`include "scl_params.svh"

package scl_pkg;

   typedef struct packed {
      logic       use_cmi;
      logic       page_64;
      logic [2:0] port_dir;
      logic [3:0] node_ident;
   } scl_strap_t;

   typedef struct packed {
      logic [7:0] o;
      logic [7:0] oe;
   } scl_pin8_t;

   typedef enum logic [1:0] {
      SCL_ST_RESET,
      SCL_ST_SETUP,
      SCL_ST_RUN
   } scl_state_t;

endpackage

// ---- design/scl_link_timer.sv ----
// Link bit tick and burst period timer
// Assumes: one clock, synchronous active-low reset
`timescale 1ns/1ps
`default_nettype none
`include "scl_params.svh"

module scl_link_timer
#(
   parameter int unsigned BURST_128_CYC = int'(`SCL_NS_TO_CYC(`SCL_BURST_128_NS)),
   parameter int unsigned BURST_64_CYC  = int'(`SCL_NS_TO_CYC(`SCL_BURST_64_NS))
)
(
   input  wire logic aclk,
   input  wire logic aresetn,
   input  wire logic run,
   input  wire logic page_64,
   output var  logic bit_tick,
   output var  logic burst_due
);

   logic [3:0]  div_cnt;
   logic [31:0] burst_cnt;
   logic [31:0] burst_end;

   assign burst_end = page_64 ? BURST_64_CYC - 1 : BURST_128_CYC - 1;

   // ****************************************
   // Bit clock
   // ****************************************
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         div_cnt  <= 4'h0;
         bit_tick <= 1'h0;
      end
      else
      begin
         bit_tick <= (div_cnt == 4'(`SCL_RATE_DIV - 1));
         div_cnt  <= (div_cnt == 4'(`SCL_RATE_DIV - 1)) ? 4'h0 : 4'(div_cnt + 4'h1);
      end
   end

   // ****************************************
   // Burst period
   // ****************************************
   always_ff @(posedge aclk)
   begin
      if (!aresetn || !run)
      begin
         burst_cnt <= 32'h0000_0000;
         burst_due <= 1'h0;
      end
      else
      begin
         burst_due <= (burst_cnt == burst_end);
         burst_cnt <= (burst_cnt == burst_end) ? 32'h0000_0000 : burst_cnt + 32'h0000_0001;
      end
   end

endmodule // scl_link_timer
`default_nettype wire

// ---- design/scl_strap_loader.sv ----
// Strap configuration loader of a standalone ring I/O node
// Assumes: AXI4-Lite master, pins synchronous to aclk, external pulls on straps
`timescale 1ns/1ps
`default_nettype none
`include "scl_params.svh"

module scl_strap_loader
#(
   parameter int unsigned ADDR_W        = 8,
   parameter int unsigned BURST_128_CYC = int'(`SCL_NS_TO_CYC(`SCL_BURST_128_NS)),
   parameter int unsigned BURST_64_CYC  = int'(`SCL_NS_TO_CYC(`SCL_BURST_64_NS))
)
(
   input  wire logic                aclk,
   input  wire logic                aresetn,
   input  wire logic [ADDR_W-1:0]   s_axi_awaddr,
   input  wire logic [2:0]          s_axi_awprot,
   input  wire logic                s_axi_awvalid,
   output var  logic                s_axi_awready,
   input  wire logic [31:0]         s_axi_wdata,
   input  wire logic [3:0]          s_axi_wstrb,
   input  wire logic                s_axi_wvalid,
   output var  logic                s_axi_wready,
   output var  logic [1:0]          s_axi_bresp,
   output var  logic                s_axi_bvalid,
   input  wire logic                s_axi_bready,
   input  wire logic [ADDR_W-1:0]   s_axi_araddr,
   input  wire logic [2:0]          s_axi_arprot,
   input  wire logic                s_axi_arvalid,
   output var  logic                s_axi_arready,
   output var  logic [31:0]         s_axi_rdata,
   output var  logic [1:0]          s_axi_rresp,
   output var  logic                s_axi_rvalid,
   input  wire logic                s_axi_rready,
   output var  scl_pkg::scl_pin8_t  port_a_pins,
   output var  scl_pkg::scl_pin8_t  port_b_pins,
   input  wire logic [7:0]          port_c_pins_i,
   output var  scl_pkg::scl_pin8_t  port_c_pins,
   input  wire logic [7:0]          port_d_pins_i,
   output var  scl_pkg::scl_pin8_t  port_d_pins,
   input  wire logic                txd_i,
   output var  logic                txd_o,
   output var  logic                txd_oe,
   input  wire logic                ext_trigger_in_1_n,
   input  wire logic                ext_trigger_in_2_n,
   output var  scl_pkg::scl_strap_t strap_config,
   output var  logic [3:0]          highest_node_ident,
   output var  logic [3:0]          next_node_ident,
   output var  logic                link_bit_tick,
   output var  logic                burst_due,
   output var  logic                trigger_pulse
);

   import scl_pkg::*;

   localparam int unsigned SKIP_CYC = int'(`SCL_NS_TO_CYC(`SCL_SKIP_NS));

   scl_state_t        state;
   scl_strap_t        straps;
   logic [3:0]        highest_set;
   logic              highest_loaded;
   logic              highest_bad;
   logic [3:0]        coding_field_msb_set;
   logic              od_a;
   logic              od_b;
   logic [31:0]       out_word;
   logic              out_seen;
   logic              aw_held;
   logic              w_held;
   logic [ADDR_W-1:0] aw_addr;
   logic [31:0]       w_data;
   logic [3:0]        w_strb;
   logic              wr_fire;
   logic              wr_ctrl;
   logic              wr_setup;
   logic              wr_out;
   logic              sw_start;
   logic              sw_reset;
   logic [31:0]       ctrl_w;
   logic [31:0]       setup_cur;
   logic [31:0]       setup_w;
   logic [3:0]        coding_field_msb;
   logic              drive_ok;
   logic              trig_n;
   logic              trig_prev;
   logic              has_trig;
   logic [31:0]       rd_data;

   // ****************************************
   // Helpers
   // ****************************************
   function automatic logic [31:0] merge_bytes(input logic [31:0] old,
                                               input logic [31:0] nw,
                                               input logic [3:0]  strb);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++)
      begin
         if (strb[i])
         begin
            res[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
      return res;
   endfunction

   function automatic logic addr_mapped(input logic [ADDR_W-1:0] a);
      logic [7:0] b;
      b = a[7:0];
      return (b == `SCL_ADDR_STATUS) || (b == `SCL_ADDR_CTRL) ||
             (b == `SCL_ADDR_SETUP)  || (b == `SCL_ADDR_TOKEN) ||
             (b == `SCL_ADDR_OUT)    || (b == `SCL_ADDR_IN);
   endfunction

   function automatic scl_strap_t strap_decode(input logic [7:0] d, input logic txd);
      scl_strap_t s;
      s.use_cmi    = txd;
      s.page_64    = d[`SCL_STRAP_PAGE];
      s.port_dir   = d[`SCL_STRAP_DIR_LSB +: 3];
      s.node_ident = {d[`SCL_STRAP_NID_MSB] & d[`SCL_STRAP_PAGE],
                      d[`SCL_STRAP_NID_MSB-1:0]};
      return s;
   endfunction

   function automatic logic highest_valid(input logic [3:0] v, input logic page_64);
      return (v >= `SCL_ID_MIN_HIGHEST) &&
             (v <= (page_64 ? `SCL_ID_MAX_LARGE : `SCL_ID_MAX_SMALL));
   endfunction

   // ****************************************
   // Strap capture and operating state
   // ****************************************
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         state  <= SCL_ST_RESET;
         straps <= '0;
      end
      else
      begin
         case (state)
            SCL_ST_RESET:
            begin
               straps <= strap_decode(port_d_pins_i, txd_i);
               state  <= SCL_ST_SETUP;
            end
            SCL_ST_SETUP:
            begin
               if (sw_start && !sw_reset)
               begin
                  state <= SCL_ST_RUN;
               end
            end
            SCL_ST_RUN:
            begin
               if (sw_reset)
               begin
                  state <= SCL_ST_SETUP;
               end
            end
            default:
            begin
               state <= SCL_ST_RESET;
            end
         endcase
      end
   end

   assign drive_ok = (state != SCL_ST_RESET);

   // ****************************************
   // Write decode
   // ****************************************
   assign wr_fire   = aw_held && w_held && !s_axi_bvalid;
   assign wr_ctrl   = wr_fire && (aw_addr[7:0] == `SCL_ADDR_CTRL);
   assign wr_setup  = wr_fire && (aw_addr[7:0] == `SCL_ADDR_SETUP) &&
                      (state == SCL_ST_SETUP);
   assign wr_out    = wr_fire && (aw_addr[7:0] == `SCL_ADDR_OUT);
   assign ctrl_w    = merge_bytes(32'h0000_0000, w_data, w_strb);
   assign sw_start  = wr_ctrl && ctrl_w[`SCL_CTRL_START];
   assign sw_reset  = wr_ctrl && ctrl_w[`SCL_CTRL_SWRST];
   assign setup_cur = {22'h00_0000, od_b, od_a, coding_field_msb_set, highest_set};
   assign setup_w   = merge_bytes(setup_cur, w_data, w_strb);

   // ****************************************
   // Network settings
   // ****************************************
   always_ff @(posedge aclk)
   begin
      if (!aresetn || sw_reset)
      begin
         highest_set          <= `SCL_SETUP_RESET_MAX;
         highest_loaded       <= 1'h0;
         highest_bad          <= 1'h0;
         coding_field_msb_set <= 4'h0;
         od_a                 <= `SCL_SETUP_RESET_BIT(`SCL_SETUP_OD_A);
         od_b                 <= `SCL_SETUP_RESET_BIT(`SCL_SETUP_OD_B);
      end
      else if (wr_setup)
      begin
         if (highest_valid(setup_w[`SCL_SETUP_MAX_LSB +: 4], straps.page_64))
         begin
            highest_set    <= setup_w[`SCL_SETUP_MAX_LSB +: 4];
            highest_loaded <= 1'h1;
         end
         else
         begin
            highest_bad <= 1'h1;
         end
         coding_field_msb_set <= setup_w[`SCL_SETUP_CODE_LSB +: 4];
         od_a                 <= setup_w[`SCL_SETUP_OD_A];
         od_b                 <= setup_w[`SCL_SETUP_OD_B];
      end
   end

   assign coding_field_msb = {coding_field_msb_set[3] & straps.page_64,
                              coding_field_msb_set[2:0]};

   // ****************************************
   // Token ring limits
   // ****************************************
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         strap_config       <= '0;
         highest_node_ident <= `SCL_ID_MAX_SMALL;
         next_node_ident    <= `SCL_ID_FIRST;
      end
      else
      begin
         strap_config <= straps;
         if (highest_loaded)
         begin
            highest_node_ident <= {highest_set[3] & straps.page_64, highest_set[2:0]};
         end
         else
         begin
            highest_node_ident <= straps.page_64 ? `SCL_ID_MAX_LARGE
                                                 : `SCL_ID_MAX_SMALL;
         end
         if (straps.node_ident >= highest_node_ident)
         begin
            next_node_ident <= `SCL_ID_FIRST;
         end
         else
         begin
            next_node_ident <= 4'(straps.node_ident + 4'h1);
         end
      end
   end

   // ****************************************
   // Port output data and pin drivers
   // ****************************************
   always_ff @(posedge aclk)
   begin
      if (!aresetn || sw_reset)
      begin
         out_word <= 32'h0000_0000;
         out_seen <= 1'h0;
      end
      else if (wr_out)
      begin
         out_word <= merge_bytes(out_word, w_data, w_strb);
         out_seen <= 1'h1;
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         port_a_pins <= '0;
         port_b_pins <= '0;
         port_c_pins <= '0;
         port_d_pins <= '0;
         txd_o       <= 1'h0;
         txd_oe      <= 1'h0;
      end
      else
      begin
         port_a_pins.o  <= od_a ? 8'h00 : out_word[7:0];
         port_a_pins.oe <= (drive_ok && out_seen) ?
                           (od_a ? ~out_word[7:0] : 8'hFF) : 8'h00;
         port_b_pins.o  <= od_b ? 8'h00 : out_word[15:8];
         port_b_pins.oe <= (drive_ok && out_seen) ?
                           (od_b ? ~out_word[15:8] : 8'hFF) : 8'h00;
         port_c_pins.o  <= out_word[23:16];
         port_c_pins.oe <= {8{drive_ok && out_seen && straps.port_dir[`SCL_DIR_C]}};
         port_d_pins.o  <= out_word[31:24];
         port_d_pins.oe[3:0] <= {4{drive_ok && out_seen && straps.port_dir[`SCL_DIR_DLO]}};
         if (straps.port_dir[`SCL_DIR_FLAG])
         begin
            port_d_pins.oe[7:4] <= {4{drive_ok}};
         end
         else
         begin
            port_d_pins.oe[7:4] <= {4{drive_ok && out_seen && straps.port_dir[`SCL_DIR_DLO]}};
         end
         txd_o  <= `SCL_TXD_IDLE;
         txd_oe <= drive_ok;
      end
   end

   // ****************************************
   // External trigger
   // ****************************************
   always_comb
   begin
      has_trig = 1'h1;
      trig_n   = ext_trigger_in_1_n;
      if (straps.port_dir[`SCL_DIR_C])
      begin
         trig_n = ext_trigger_in_2_n;
         if (straps.port_dir[`SCL_DIR_DLO])
         begin
            has_trig = 1'h0;
            trig_n   = 1'h1;
         end
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         trig_prev     <= 1'h1;
         trigger_pulse <= 1'h0;
      end
      else
      begin
         trig_prev     <= trig_n;
         trigger_pulse <= has_trig && (state == SCL_ST_RUN) && trig_prev && !trig_n;
      end
   end

   // ****************************************
   // Link timing
   // ****************************************
   scl_link_timer
   #(
      .BURST_128_CYC (BURST_128_CYC),
      .BURST_64_CYC  (BURST_64_CYC)
   )
   u_timer
   (
      .aclk      (aclk),
      .aresetn   (aresetn),
      .run       (state == SCL_ST_RUN),
      .page_64   (straps.page_64),
      .bit_tick  (link_bit_tick),
      .burst_due (burst_due)
   );

   // ****************************************
   // AXI4-Lite write channels
   // ****************************************
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_awready <= 1'h0;
         aw_held       <= 1'h0;
         aw_addr       <= '0;
      end
      else if (s_axi_awvalid && s_axi_awready)
      begin
         s_axi_awready <= 1'h0;
         aw_held       <= 1'h1;
         aw_addr       <= s_axi_awaddr;
      end
      else if (wr_fire)
      begin
         aw_held <= 1'h0;
      end
      else if (!aw_held && !s_axi_bvalid)
      begin
         s_axi_awready <= 1'h1;
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_wready <= 1'h0;
         w_held       <= 1'h0;
         w_data       <= 32'h0000_0000;
         w_strb       <= 4'h0;
      end
      else if (s_axi_wvalid && s_axi_wready)
      begin
         s_axi_wready <= 1'h0;
         w_held       <= 1'h1;
         w_data       <= s_axi_wdata;
         w_strb       <= s_axi_wstrb;
      end
      else if (wr_fire)
      begin
         w_held <= 1'h0;
      end
      else if (!w_held && !s_axi_bvalid)
      begin
         s_axi_wready <= 1'h1;
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_bvalid <= 1'h0;
         s_axi_bresp  <= `SCL_RESP_OKAY;
      end
      else if (wr_fire)
      begin
         s_axi_bvalid <= 1'h1;
         s_axi_bresp  <= addr_mapped(aw_addr) ? `SCL_RESP_OKAY : `SCL_RESP_SLVERR;
      end
      else if (s_axi_bready)
      begin
         s_axi_bvalid <= 1'h0;
      end
   end

   // ****************************************
   // AXI4-Lite read channels
   // ****************************************
   always_comb
   begin
      rd_data = 32'h0000_0000;
      case (s_axi_araddr[7:0])
         `SCL_ADDR_STATUS:
         begin
            rd_data = {16'h0000, (state == SCL_ST_RUN), highest_bad,
                       highest_loaded, straps.use_cmi, straps.page_64,
                       straps.port_dir, coding_field_msb, straps.node_ident};
         end
         `SCL_ADDR_SETUP:
         begin
            rd_data = setup_cur;
         end
         `SCL_ADDR_TOKEN:
         begin
            rd_data = {16'(SKIP_CYC), 8'h00, next_node_ident, highest_node_ident};
         end
         `SCL_ADDR_OUT:
         begin
            rd_data = out_word;
         end
         `SCL_ADDR_IN:
         begin
            rd_data = {15'h0000, trig_n, port_d_pins_i, port_c_pins_i};
         end
         default:
         begin
            rd_data = 32'h0000_0000;
         end
      endcase
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_arready <= 1'h0;
         s_axi_rvalid  <= 1'h0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= `SCL_RESP_OKAY;
      end
      else if (s_axi_arvalid && s_axi_arready)
      begin
         s_axi_arready <= 1'h0;
         s_axi_rvalid  <= 1'h1;
         s_axi_rdata   <= rd_data;
         s_axi_rresp   <= addr_mapped(s_axi_araddr) ? `SCL_RESP_OKAY : `SCL_RESP_SLVERR;
      end
      else if (s_axi_rvalid)
      begin
         if (s_axi_rready)
         begin
            s_axi_rvalid <= 1'h0;
         end
      end
      else
      begin
         s_axi_arready <= 1'h1;
      end
   end

endmodule // scl_strap_loader
`default_nettype wire

// ---- test/scl_strap_loader_properties.sv ----
// Port assertions for the strap loader
// Assumes: bound to scl_strap_loader, one clock domain
`timescale 1ns/1ps
`default_nettype none
module scl_strap_props (
   input wire logic                aclk,
   input wire logic                aresetn,
   input wire logic [7:0]          port_d_pins_i,
   input wire logic                txd_i,
   input wire logic                txd_oe,
   input wire scl_pkg::scl_pin8_t  port_c_pins,
   input wire scl_pkg::scl_pin8_t  port_d_pins,
   input wire scl_pkg::scl_strap_t strap_config,
   input wire logic [3:0]          highest_node_ident,
   input wire logic                link_bit_tick,
   input wire logic                ext_trigger_in_1_n,
   input wire logic                ext_trigger_in_2_n,
   input wire logic                trigger_pulse
);
   import scl_pkg::*;
   logic [8:0] sq;
   logic       rq;
   logic       tsel;
   // Pins as seen at the first edge out of reset
   always_ff @(posedge aclk)
   begin
      rq <= aresetn;
      if (!rq)
      begin
         sq <= {txd_i, port_d_pins_i};
      end
   end
   // Trigger level chosen by the direction straps, high when none
   assign tsel = strap_config.port_dir[0] ? (strap_config.port_dir[1] | ext_trigger_in_2_n)
                                          : ext_trigger_in_1_n;
   // *****
   // Checks
   // *****
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   a_off_in_reset: assert property (disable iff (1'b0)
      !aresetn |=> {port_c_pins.oe, port_d_pins.oe, txd_oe} == 17'h0) else $error("pin driven");
   a_strap_capture: assert property ($rose(aresetn) |=> ##1
      strap_config == {sq[8], sq[4], sq[7:5], sq[4] & sq[3], sq[2:0]}) else $error("capture");
   a_straps_held: assert property ($past(aresetn, 2) |=> $stable(strap_config))
      else $error("straps moved");
   a_flag_drive: assert property ($past(aresetn) && strap_config.port_dir[2] |=>
      port_d_pins.oe[7:4] == 4'hF) else $error("flags off");
   a_port_c_dir: assert property (|port_c_pins.oe |-> strap_config.port_dir[0])
      else $error("port C driven");
   a_port_d_dir: assert property (|port_d_pins.oe[3:0] |-> strap_config.port_dir[1])
      else $error("port D driven");
   a_highest_range: assert property ($past(aresetn, 3) |->
      highest_node_ident >= 4'h2 && (strap_config.page_64 || !highest_node_ident[3]))
      else $error("highest id");
   a_bit_period: assert property (
      link_bit_tick |=> !link_bit_tick [*7] ##1 link_bit_tick) else $error("bit period");
   a_trig_select: assert property (trigger_pulse |-> $past(tsel, 2) && !$past(tsel))
      else $error("trigger source");
   c_release: cover property ($rose(aresetn));
   c_trigger: cover property (trigger_pulse);
   c_flags: cover property (port_d_pins.oe[7]);
   c_port_c: cover property (|port_c_pins.oe);
endmodule // scl_strap_props

bind scl_strap_loader scl_strap_props u_props (.aclk, .aresetn, .port_d_pins_i, .txd_i,
   .txd_oe, .port_c_pins, .port_d_pins, .strap_config, .highest_node_ident, .link_bit_tick,
   .ext_trigger_in_1_n, .ext_trigger_in_2_n, .trigger_pulse);
`default_nettype wire

// ---- test/scl_board_model.sv ----
// Board side of the shared strap pins
// Assumes: loader output enables decide who drives each pin
`timescale 1ns/1ps
`default_nettype none
module scl_board_model (
   input wire logic [8:0]         pulls,
   input wire scl_pkg::scl_pin8_t port_d_pins,
   input wire logic               txd_o,
   input wire logic               txd_oe,
   output var logic [7:0]         port_d_pins_i,
   output var logic               txd_i
);
   import scl_pkg::*;
   // Released pins fall back to their pulls
   assign port_d_pins_i = (port_d_pins.oe & port_d_pins.o)
                        | (~port_d_pins.oe & pulls[7:0]);
   assign txd_i = txd_oe ? txd_o : pulls[8];
endmodule // scl_board_model
`default_nettype wire

// ---- test/scl_strap_loader_test.sv ----
// Self-checking bench for the strap loader
// Assumes: package, board model and bound checker compiled first
`timescale 1ns/1ps
`default_nettype none
module scl_strap_loader_test;
   import scl_pkg::*;
   logic        aclk, aresetn, txd_i, txd_o, txd_oe, ext_trigger_in_1_n, ext_trigger_in_2_n;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
   logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_bready, s_axi_rready;
   logic [7:0]  s_axi_awaddr, s_axi_araddr, port_c_pins_i, port_d_pins_i;
   logic [31:0] s_axi_wdata, s_axi_rdata, rv, d;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp, rr;
   logic [8:0]  pulls, p;
   scl_pin8_t   port_a_pins, port_b_pins, port_c_pins, port_d_pins;
   scl_strap_t  strap_config;
   logic [3:0]  vs [6] = '{4'h1, 4'h2, 4'h7, 4'h8, 4'hF, 4'h0};
   int          miscompares, compares;

   scl_strap_loader #(.BURST_128_CYC(40), .BURST_64_CYC(30)) u_dut (.aclk, .aresetn,
      .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .port_a_pins, .port_b_pins, .port_c_pins_i,
      .port_c_pins, .port_d_pins_i, .port_d_pins, .txd_i, .txd_o, .txd_oe, .ext_trigger_in_1_n,
      .ext_trigger_in_2_n, .strap_config, .highest_node_ident(), .next_node_ident(),
      .link_bit_tick(), .burst_due(), .trigger_pulse());

   scl_board_model u_board (.pulls, .port_d_pins, .txd_o, .txd_oe, .port_d_pins_i, .txd_i);

   initial
   begin
      aclk = 1'b0;
      forever #20 aclk = ~aclk;
   end

   always @(posedge aclk)
   begin
      port_c_pins_i      <= 8'($urandom);
      ext_trigger_in_1_n <= 1'($urandom);
      ext_trigger_in_2_n <= 1'($urandom);
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp)
      begin
         miscompares++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      s_axi_awaddr  <= a;
      s_axi_wdata   <= v;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (s_axi_awready)
            s_axi_awvalid <= 1'b0;
         if (s_axi_wready)
            s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      rr = s_axi_bresp;
   endtask

   task automatic rd(input logic [7:0] a);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (s_axi_arready)
            s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      rv = s_axi_rdata;
      rr = s_axi_rresp;
   endtask

   function automatic logic [3:0] top_id(input logic [8:0] s);
      return s[4] ? 4'hF : 4'h7;
   endfunction

   // Token word: skip latency 1872 cycles, next node, highest node
   function automatic logic [31:0] exp_tok(input logic [8:0] s, input logic [3:0] h);
      logic [3:0] n;
      n = {s[4] & s[3], s[2:0]};
      return {16'h0750, 8'h00, (n >= h) ? 4'h1 : 4'(n + 4'h1), h};
   endfunction

   function automatic logic [3:0] exp_hi(input logic [8:0] s, input logic [3:0] v);
      return (v >= 4'h2 && v <= top_id(s)) ? v : top_id(s);
   endfunction

   function automatic logic [31:0] exp_status(input logic [8:0] s, input logic [3:0] v,
                                              input logic run);
      logic ok;
      ok = exp_hi(s, v) == v;
      return {16'h0, run, run & ~ok, run & ok, s[8], s[4], s[7:5],
              top_id(s) & {4{run}}, s[4] & s[3], s[2:0]};
   endfunction

   task automatic tally_and_finish();
      if (miscompares == 0 && compares > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   // *****
   // Main sequence
   // *****
   initial
   begin
      {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, s_axi_awaddr, s_axi_araddr} = '0;
      {s_axi_wdata, pulls, port_c_pins_i} = '0;
      {s_axi_bready, s_axi_rready, s_axi_wstrb, ext_trigger_in_1_n, ext_trigger_in_2_n} = '1;
      void'($urandom(1));
      for (int i = 0; i < 6; i++)
      begin
         p = 9'($urandom);
         d = $urandom;
         if ({p[4] & p[3], p[2:0]} == 4'h0)
            p[0] = 1'b1;
         aresetn <= 1'b0;
         pulls   <= p;
         repeat (12) @(posedge aclk);
         aresetn <= 1'b1;
         repeat (3) @(posedge aclk);
         pulls <= ~p;
         chk(strap_config, {p[8], p[4], p[7:5], p[4] & p[3], p[2:0]});
         rd(8'h00);
         chk(rv, exp_status(p, 4'h0, 1'b0));
         rd(8'h0C);
         chk(rv, exp_tok(p, top_id(p)));
         wr(8'h08, {22'h0, 2'b11, 4'hF, vs[i]});
         chk(rr, 2'h0);
         wr(8'h04, 32'h0000_0001);
         wr(8'h08, 32'h0000_0302);
         rd(8'h0C);
         chk(rv, exp_tok(p, exp_hi(p, vs[i])));
         rd(8'h00);
         chk(rv, exp_status(p, vs[i], 1'b1));
         chk(port_c_pins.oe, 8'h00);
         wr(8'h10, d);
         repeat (2) @(posedge aclk);
         chk({port_c_pins.oe, port_d_pins.oe[3:0]}, {{8{p[5]}}, {4{p[6]}}});
         chk({port_a_pins, port_b_pins}, {8'h00, ~d[7:0], 8'h00, ~d[15:8]});
         wr(8'h04, 32'h0000_0002);
         rd(8'h00);
         chk(rv, exp_status(p, 4'h0, 1'b0));
         chk(port_c_pins.oe, 8'h00);
         wr(8'h18, d);
         chk(rr, 2'h2);
      end
      tally_and_finish();
   end

   initial
   begin
      repeat (5000) @(posedge aclk);
      miscompares++;
      tally_and_finish();
   end
endmodule // scl_strap_loader_test
`default_nettype wire
